// >>> bench/asc_conv_model.sv
// Converter stand-in: one result per start pulse.
// Assumes conv_start is a one-cycle pulse.
`timescale 1ns/1ps
module asc_conv_model #(parameter [7:0] DLY = 8'h06) (
   input wire aclk,
   input wire aresetn,
   input wire conv_start,
   input wire [11:0] value,
   output reg conv_done,
   output reg [11:0] conv_data
);
   reg [7:0] cnt_reg;
   always @(posedge aclk) begin
      conv_done <= 1'b0;
      // Data toggles outside the done pulse so stale use shows
      conv_data <= ~conv_data;
      if (!aresetn) begin
         cnt_reg <= 8'h00;
         conv_data <= 12'h000;
      end else if (conv_start) begin
         cnt_reg <= DLY;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
         if (cnt_reg == 8'h01) begin
            conv_done <= 1'b1;
            conv_data <= value;
         end
      end
   end
endmodule

// >>> bench/asc_props.sv
// Port checker for the converter sequence control.
// Bound into every asc_seq_ctrl instance.
`timescale 1ns/1ps
module asc_props (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire conv_start,
   input wire conv_done,
   input wire irq_enable,
   input wire adc_irq,
   input wire dma_request
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   a_aw_refused: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("write taken early");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read not answered");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken early");
   a_start_once: assert property (conv_start |=> !conv_start)
      else $error("start longer than one cycle");
   a_irq_gated: assert property (adc_irq |-> irq_enable)
      else $error("interrupt while disabled");
   a_irq_cause: assert property ($rose(adc_irq) |->
      $past(conv_done) || $rose(irq_enable)) else $error("stray interrupt");
   a_dma_cause: assert property (dma_request |-> $past(conv_done))
      else $error("dma request without result");
endmodule
bind asc_seq_ctrl asc_props u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .conv_start(conv_start), .conv_done(conv_done),
   .irq_enable(irq_enable), .adc_irq(adc_irq), .dma_request(dma_request));

// >>> bench/testbench.sv
// Self-checking bench for the converter sequence control.
// Assumes the converter model and the bound port checker.
`timescale 1ns/1ps
`include "asc_regs.vh"
module testbench;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [7:0] awaddr = 8'h00, araddr = 8'h00;
   reg [31:0] wdata = 32'h0, rd_v;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   reg arvalid = 1'b0, rready = 1'b0, idle = 1'b0, irq_en = 1'b0;
   reg [11:0] trg = 12'h000, value = 12'h000;
   reg [1:0] rd_r;
   wire awready, wready, bvalid, arready, rvalid, conv_start;
   wire conv_done, adc_irq;
   wire [1:0] rresp;
   wire [31:0] rdata;
   wire [11:0] conv_data;
   integer n_fail = 0, samples_checked = 0, n_start = 0;
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) if (conv_start) n_start = n_start + 1;
   asc_seq_ctrl dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .idle_mode(idle),
      .irq_enable(irq_en), .pwm_gen_trig(trg[2:0]),
      .trigger_gen_out(trg[6:3]), .charge_time_unit(trg[7]),
      .timer5_match(trg[8]), .pwm_special_event(trg[9]),
      .timer3_match(trg[10]), .external_irq_zero(trg[11]),
      .conv_start(conv_start), .sample_channels(), .scan_index(),
      .conv_done(conv_done), .conv_data(conv_data), .adc_irq(adc_irq),
      .dma_request(), .dma_address());
   asc_conv_model #(.DLY(8'h14)) cm (.aclk(aclk), .aresetn(aresetn),
      .conv_start(conv_start), .value(value), .conv_done(conv_done),
      .conv_data(conv_data));
   function [15:0] fmt(input twelve, input [1:0] f, input [11:0] v);
      reg [15:0] l;
      reg signed [15:0] s;
      begin
         l = twelve ? {v, 4'h0} : {v[9:0], 6'h00};
         s = {~l[15], l[14:0]};
         case (f)
            2'b00: fmt = twelve ? l >> 4 : l >> 6;
            2'b01: fmt = twelve ? s >>> 4 : s >>> 6;
            2'b10: fmt = l;
            default: fmt = s;
         endcase
      end
   endfunction
   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", samples_checked, n_fail);
         if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end while ((awvalid && !awready) || (wvalid && !wready));
         do @(posedge aclk); while (!bvalid);
         bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do @(posedge aclk); while (!arready);
         arvalid <= 1'b0;
         do @(posedge aclk); while (!rvalid);
         rready <= 1'b0;
         rd_v = rdata;
         rd_r = rresp;
      end
   endtask
   // Manual mode: sample bit set, then cleared to convert
   task conv(input [15:0] c, input [11:0] v);
      integer t;
      begin
         value <= v;
         wr(`ASC_OFF_CTRL1, {16'h0, c | 16'h0001});
         wr(`ASC_OFF_CTRL1, {16'h0, c | 16'h0003});
         wr(`ASC_OFF_CTRL1, {16'h0, c | 16'h0001});
         rd(`ASC_OFF_CTRL1);
         chk("done low", 32'h0, {31'h0, rd_v[0]});
         t = 0;
         while (!conv_done && t < 100) begin
            @(posedge aclk);
            t = t + 1;
         end
         chk("conv done", 32'h1, {31'h0, t < 100});
         repeat (2) @(posedge aclk);
      end
   endtask
   task pulse(input integer idx);
      begin
         @(posedge aclk);
         trg[idx] <= 1'b1;
         @(posedge aclk);
         trg <= 12'h000;
         // Long enough for the internal counter trigger too
         repeat (8) @(posedge aclk);
      end
   endtask
   task t_reset;
      begin
         rd(`ASC_OFF_CTRL1);
         chk("ctrl1 reset", {16'h0, `ASC_CTRL1_RST}, rd_v);
         rd(8'h30);
         chk("unmapped", {30'h0, `ASC_RESP_SLVERR}, {30'h0, rd_r});
      end
   endtask
   task t_format;
      integer r, f;
      reg [11:0] v;
      begin
         v = 12'h9a5;
         for (r = 0; r < 2; r = r + 1) begin
            for (f = 0; f < 4; f = f + 1) begin
               conv({5'h10, r[0], f[1:0], 8'h00}, v);
               rd(`ASC_OFF_BUF);
               chk("result", {16'h0, fmt(r[0], f[1:0], v)}, rd_v);
               rd(`ASC_OFF_CTRL1);
               chk("done set", 32'h1, {31'h0, rd_v[0]});
            end
         end
      end
   endtask
   task t_seq;
      integer i;
      begin
         wr(`ASC_OFF_CTRL2, 32'h0000000c);
         // Flag is still set from the format runs
         wr(`ASC_OFF_STAT, 32'h1);
         irq_en <= 1'b1;
         for (i = 0; i < 4; i = i + 1) begin
            conv(16'h8000, 12'h100 + i[11:0]);
            chk("irq", {31'h0, i == 3}, {31'h0, adc_irq});
         end
         for (i = 0; i < 4; i = i + 1) begin
            rd(`ASC_OFF_BUF + {i[5:0], 2'b00});
            chk("word", 32'h100 + i, rd_v);
         end
         chk("irq held", 32'h1, {31'h0, adc_irq});
         wr(`ASC_OFF_STAT, 32'h1);
         chk("irq clear", 32'h0, {31'h0, adc_irq});
         conv(16'h8000, 12'h0aa);
         rd(`ASC_OFF_BUF);
         chk("wrap", 32'h0aa, rd_v);
      end
   endtask
   task t_done;
      begin
         wr(`ASC_OFF_CTRL1, 32'h8000);
         rd(`ASC_OFF_CTRL1);
         chk("done cleared", 32'h0, {31'h0, rd_v[0]});
         wr(`ASC_OFF_CTRL1, 32'h8001);
         rd(`ASC_OFF_CTRL1);
         chk("done one", 32'h0, {31'h0, rd_v[0]});
      end
   endtask
   task t_dma;
      begin
         wr(`ASC_OFF_CTRL2, 32'h0);
         wr(`ASC_OFF_CTRL4, 32'h100);
         conv(16'h9000, 12'h011);
         rd(`ASC_OFF_BUF);
         chk("dma word", 32'h011, rd_v);
         conv(16'h9000, 12'h022);
         rd(`ASC_OFF_BUF);
         chk("dma word2", 32'h022, rd_v);
         rd(`ASC_OFF_DMAADR);
         chk("dma addr", 32'h2, rd_v);
         wr(`ASC_OFF_CTRL4, 32'h0);
      end
   endtask
   task t_trig;
      integer g, k, s;
      begin
         for (g = 0; g < 2; g = g + 1) begin
            for (k = 0; k < 8; k = k + 1) begin
               if ((g == 1 && k != 7) || (g == 0 && k != 0 && k != 5)) begin
                  wr(`ASC_OFF_CTRL1, {24'h000080, k[2:0], g[0], 4'h3});
                  s = n_start;
                  pulse(g ? k : (k == 6 ? 7 : 12 - k));
                  chk("trigger", s + 1, n_start);
                  rd(`ASC_OFF_CTRL1);
                  chk("sample_bit", 32'h0, {31'h0, rd_v[1]});
                  repeat (25) @(posedge aclk);
               end
            end
         end
         // Off, then on but stopped in idle: triggers must do nothing
         for (g = 0; g < 2; g = g + 1) begin
            idle <= g[0];
            wr(`ASC_OFF_CTRL1, {16'h0, g[0], 1'b0, g[0], 13'h0043});
            s = n_start;
            pulse(10);
            chk("ignored", s, n_start);
         end
         idle <= 1'b0;
      end
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_format;
      t_seq;
      t_done;
      t_dma;
      t_trig;
      tally_and_finish;
   end
   initial begin
      #500000;
      n_fail = n_fail + 1;
      tally_and_finish;
   end
endmodule

// >>> hdl/asc_regs.vh
// Register offsets, field positions, reset values and timing for the
// converter sequence control. Definitions only.
`ifndef ASC_REGS_VH
`define ASC_REGS_VH

`define ASC_OFF_CTRL1 8'h00
`define ASC_OFF_CTRL2 8'h04
`define ASC_OFF_CTRL4 8'h08
`define ASC_OFF_STAT 8'h0c
`define ASC_OFF_SCAN 8'h10
`define ASC_OFF_DMAADR 8'h14
`define ASC_OFF_BUF 8'h40

`define ASC_B_ON 15
`define ASC_B_SIDL 13
`define ASC_B_DMABM 12
`define ASC_B_RES 10
`define ASC_B_FMT_HI 9
`define ASC_B_FMT_LO 8
`define ASC_B_SRC_HI 7
`define ASC_B_SRC_LO 5
`define ASC_B_GRP 4
`define ASC_B_SIM 3
`define ASC_B_AUTO_SAMPLE_START 2
`define ASC_B_SAMPLE_BIT 1
`define ASC_B_DONE 0

`define ASC_B_SCAN 10
`define ASC_B_CHANNEL_COUNT_SELECT_HI 9
`define ASC_B_CHANNEL_COUNT_SELECT_LO 8
`define ASC_B_RATE_HI 6
`define ASC_B_RATE_LO 2
`define ASC_B_DMAEN 8

`define ASC_CTRL1_RST 16'h0000
`define ASC_CTRL1_WMASK 16'hb7fc
`define ASC_CTRL2_WMASK 16'h077c
`define ASC_CTRL4_WMASK 16'h0107

`define ASC_AUTO_NS 200
`define ASC_AUTO_CYC 8'h08
`define ASC_RESP_OKAY 2'b00
`define ASC_RESP_SLVERR 2'b10

`endif

// >>> hdl/asc_seq_ctrl.v
// Converter sequence control: sample/convert sequencing, result formatting,
// sixteen-word result buffer or single word for DMA, AXI4-Lite registers.
// Assumes an external converter that answers conv_start with conv_done.
`timescale 1ns/1ps
`include "asc_regs.vh"

// Overview of operation
// - Interrupt flag after interrupt-rate conversions, gated by enable
// - Scan list restarts when rate count completes
// - Non-DMA buffer pointer returns to word zero
// - DMA: results in word zero, rate advances address
// - Sixteen words filled in conversion order
// - Done cleared at conversion start, set at end
// - Software writes zero clear done, ones ignored
// - Converter runs only while module on is set
// - Stop in idle halts operation during idle
// - DMA address in order or scatter/gather
// - Resolution bit picks 12-bit or 10-bit
// - Ten-bit results formatted by format field
// - Twelve-bit results formatted by same codes
// - Group one triggers: PWM 1-3, generator outs
// - Group zero triggers by source code
// - Simultaneous sample in 10-bit mode only
// - Auto start resamples after each conversion
// - Code zero: software clears sample bit
// - Software sets sample bit to start sampling
// - Non-DMA interrupt every low-four-bits plus one
// - DMA advance every five-bit rate plus one
module asc_seq_ctrl (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire idle_mode,
   input wire irq_enable,
   input wire [2:0] pwm_gen_trig,
   input wire [3:0] trigger_gen_out,
   input wire charge_time_unit,
   input wire timer5_match,
   input wire pwm_special_event,
   input wire timer3_match,
   input wire external_irq_zero,
   output wire conv_start,
   output wire [3:0] sample_channels,
   output wire [3:0] scan_index,
   input wire conv_done,
   input wire [11:0] conv_data,
   output wire adc_irq,
   output wire dma_request,
   output wire [15:0] dma_address
);

   localparam ST_IDLE = 2'd0;
   localparam ST_SAMPLE = 2'd1;
   localparam ST_CONV = 2'd2;

   reg [15:0] ctrl1_reg;
   reg [15:0] ctrl2_reg;
   reg [15:0] ctrl4_reg;
   reg [15:0] scan_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [15:0] buf_mem [0:15];
   reg [3:0] wptr_reg;
   reg [4:0] rate_cnt_reg;
   reg [3:0] scan_pos_reg;
   reg [15:0] dma_addr_reg;
   reg irq_flag_reg;
   reg dma_req_reg;
   reg ext0_d_reg;
   reg [7:0] auto_cnt_reg;
   reg conv_start_reg;
   reg [15:0] fmt_data;
   reg trig;
   reg aw_held_reg;
   reg w_held_reg;
   reg [7:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;
   reg [31:0] rd_word;
   reg rd_ok;

   wire on = ctrl1_reg[`ASC_B_ON] &
      ~(ctrl1_reg[`ASC_B_SIDL] & idle_mode);
   wire res12 = ctrl1_reg[`ASC_B_RES];
   wire [2:0] src = ctrl1_reg[`ASC_B_SRC_HI:`ASC_B_SRC_LO];
   wire dma_on = ctrl4_reg[`ASC_B_DMAEN];
   wire [4:0] rate = ctrl2_reg[`ASC_B_RATE_HI:`ASC_B_RATE_LO];
   // Non-DMA uses only the low four bits
   wire [4:0] rate_lim = dma_on ? rate : {1'b0, rate[3:0]};
   // Compare by >= so a rate lowered mid-count still wraps at once
   wire rate_hit = conv_done & (state_reg == ST_CONV) &
      (rate_cnt_reg >= rate_lim);
   wire ext0_edge = external_irq_zero & ~ext0_d_reg;
   wire wr_do = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire wr_ctrl1 = wr_do & (awaddr_reg == `ASC_OFF_CTRL1);
   wire [15:0] wd = wdata_reg[15:0];
   wire [15:0] wmask1 = `ASC_CTRL1_WMASK;

   assign s_axi_awready = ~aw_held_reg;
   assign s_axi_wready = ~w_held_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign conv_start = conv_start_reg;
   assign adc_irq = irq_flag_reg & irq_enable;
   assign dma_request = dma_req_reg;
   assign dma_address = dma_addr_reg;
   assign scan_index = scan_pos_reg;
   // Channel set sampled together; 12-bit has one sample/hold
   assign sample_channels = (res12 | ~ctrl1_reg[`ASC_B_SIM]) ? 4'h1 :
      ctrl2_reg[`ASC_B_CHANNEL_COUNT_SELECT_HI] ? 4'hf :
      ctrl2_reg[`ASC_B_CHANNEL_COUNT_SELECT_LO] ? 4'h3 : 4'h1;

   // Trigger select that ends sampling
   always @* begin
      trig = 1'b0;
      if (ctrl1_reg[`ASC_B_GRP]) begin
         case (src)
            3'h0: trig = pwm_gen_trig[0];
            3'h1: trig = pwm_gen_trig[1];
            3'h2: trig = pwm_gen_trig[2];
            3'h3: trig = trigger_gen_out[0];
            3'h4: trig = trigger_gen_out[1];
            3'h5: trig = trigger_gen_out[2];
            3'h6: trig = trigger_gen_out[3];
            default: trig = 1'b0;
         endcase
      end else begin
         case (src)
            3'h7: trig = (auto_cnt_reg == `ASC_AUTO_CYC);
            3'h6: trig = charge_time_unit;
            3'h4: trig = timer5_match;
            3'h3: trig = pwm_special_event;
            3'h2: trig = timer3_match;
            3'h1: trig = ext0_edge;
            3'h0: trig = wr_ctrl1 & ~wd[`ASC_B_SAMPLE_BIT];
            default: trig = 1'b0;
         endcase
      end
   end

   // Result formatting
   always @* begin
      fmt_data = 16'h0000;
      if (res12) begin
         case (ctrl1_reg[`ASC_B_FMT_HI:`ASC_B_FMT_LO])
            2'b00: fmt_data = {4'h0, conv_data};
            2'b01: fmt_data = {{5{~conv_data[11]}}, conv_data[10:0]};
            2'b10: fmt_data = {conv_data, 4'h0};
            default: fmt_data = {~conv_data[11], conv_data[10:0], 4'h0};
         endcase
      end else begin
         case (ctrl1_reg[`ASC_B_FMT_HI:`ASC_B_FMT_LO])
            2'b00: fmt_data = {6'h00, conv_data[9:0]};
            2'b01: fmt_data = {{7{~conv_data[9]}}, conv_data[8:0]};
            2'b10: fmt_data = {conv_data[9:0], 6'h00};
            default: fmt_data = {~conv_data[9], conv_data[8:0], 6'h00};
         endcase
      end
   end

   // Sequencer
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (on & (ctrl1_reg[`ASC_B_AUTO_SAMPLE_START] |
               (wr_ctrl1 & wd[`ASC_B_SAMPLE_BIT])))
               state_next = ST_SAMPLE;
         ST_SAMPLE:
            if (trig)
               state_next = ST_CONV;
         ST_CONV:
            if (conv_done)
               state_next = ctrl1_reg[`ASC_B_AUTO_SAMPLE_START] ? ST_SAMPLE : ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
      if (!on)
         state_next = ST_IDLE;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
         ctrl1_reg <= `ASC_CTRL1_RST;
         ctrl2_reg <= 16'h0000;
         ctrl4_reg <= 16'h0000;
         scan_reg <= 16'h0000;
         wptr_reg <= 4'h0;
         rate_cnt_reg <= 5'h00;
         scan_pos_reg <= 4'h0;
         dma_addr_reg <= 16'h0000;
         irq_flag_reg <= 1'b0;
         dma_req_reg <= 1'b0;
         ext0_d_reg <= 1'b0;
         auto_cnt_reg <= 8'h00;
         conv_start_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ext0_d_reg <= external_irq_zero;
         conv_start_reg <= (state_reg == ST_SAMPLE) & (state_next == ST_CONV);
         dma_req_reg <= 1'b0;
         auto_cnt_reg <= (state_reg == ST_SAMPLE) ?
            auto_cnt_reg + 8'h01 : 8'h00;
         if (wr_do & (awaddr_reg == `ASC_OFF_CTRL2))
            ctrl2_reg <= wd & `ASC_CTRL2_WMASK;
         if (wr_do & (awaddr_reg == `ASC_OFF_CTRL4))
            ctrl4_reg <= wd & `ASC_CTRL4_WMASK;
         if (wr_do & (awaddr_reg == `ASC_OFF_SCAN))
            scan_reg <= wd;
         // Status write: one in bit 0 clears the flag
         if (wr_do & (awaddr_reg == `ASC_OFF_STAT) & wd[0])
            irq_flag_reg <= 1'b0;
         if (wr_ctrl1) begin
            ctrl1_reg[15:2] <= wd[15:2] & wmask1[15:2];
            if (!wd[`ASC_B_DONE])
               ctrl1_reg[`ASC_B_DONE] <= 1'b0;
         end
         // Sample bit mirrors the sample phase
         ctrl1_reg[`ASC_B_SAMPLE_BIT] <= (state_next == ST_SAMPLE);
         if (state_next == ST_CONV && state_reg == ST_SAMPLE)
            ctrl1_reg[`ASC_B_DONE] <= 1'b0;
         if (state_reg == ST_CONV && conv_done) begin
            ctrl1_reg[`ASC_B_DONE] <= 1'b1;
            if (dma_on) begin
               buf_mem[0] <= fmt_data;
               dma_req_reg <= 1'b1;
            end else begin
               buf_mem[wptr_reg] <= fmt_data;
               wptr_reg <= rate_hit ? 4'h0 : wptr_reg + 4'h1;
            end
            rate_cnt_reg <= rate_hit ? 5'h00 : rate_cnt_reg + 5'h01;
            // Next scan entry in order, else restart
            if (ctrl2_reg[`ASC_B_SCAN])
               scan_pos_reg <= rate_hit ? 4'h0 :
                  scan_pos_reg + 4'h1;
            if (rate_hit) begin
               irq_flag_reg <= 1'b1;
               if (dma_on)
                  dma_addr_reg <= ctrl1_reg[`ASC_B_DMABM] ?
                     dma_addr_reg + 16'h0001 :
                     {8'h00, scan_pos_reg, 4'h0} +
                     ({13'h0000, ctrl4_reg[2:0]});
            end
         end
      end
   end

   // AXI4-Lite write side; address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         bvalid_reg <= 1'b0;
         bresp_reg <= `ASC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid & ~aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid & ~w_held_reg) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
         end
         if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (awaddr_reg <= `ASC_OFF_SCAN) ?
               `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
         end
         if (bvalid_reg & s_axi_bready) begin
            bvalid_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
         end
      end
   end

   // Read decode; buffer words are read only
   always @* begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      if (s_axi_araddr >= `ASC_OFF_BUF)
         rd_word = {16'h0000, buf_mem[s_axi_araddr[5:2]]};
      else case ({s_axi_araddr[7:2], 2'b00})
         `ASC_OFF_CTRL1: rd_word = {16'h0000, ctrl1_reg[15:4],
            ctrl1_reg[3] & ~res12, ctrl1_reg[2:0]};
         `ASC_OFF_CTRL2: rd_word = {16'h0000, ctrl2_reg};
         `ASC_OFF_CTRL4: rd_word = {16'h0000, ctrl4_reg};
         `ASC_OFF_STAT: rd_word = {27'h0000000, wptr_reg, irq_flag_reg};
         `ASC_OFF_SCAN: rd_word = {16'h0000, scan_reg};
         `ASC_OFF_DMAADR: rd_word = {16'h0000, dma_addr_reg};
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `ASC_RESP_OKAY;
      end else if (s_axi_arvalid & ~rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_ok ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule
